// >>> hw/rg_pkg.sv
package rg_pkg;
   // ---------------------------------------------------------------
   // register word offsets (byte addresses, one aligned word each)
   // ---------------------------------------------------------------
   localparam logic [7:0] OFS_CTRL    = 8'h00;
   localparam logic [7:0] OFS_TALO    = 8'h04;
   localparam logic [7:0] OFS_TAHI    = 8'h08;
   localparam logic [7:0] OFS_TILO    = 8'h0C;
   localparam logic [7:0] OFS_TIHI    = 8'h10;
   localparam logic [7:0] OFS_LINE    = 8'h14;
   localparam logic [7:0] OFS_VOH     = 8'h18;
   localparam logic [7:0] OFS_DCOFS   = 8'h1C;
   localparam logic [7:0] OFS_FRHI    = 8'h20;
   localparam logic [7:0] OFS_FRLO    = 8'h24;
   localparam logic [7:0] OFS_AMP     = 8'h28;
   localparam logic [7:0] OFS_EXTV    = 8'h2C;
   localparam logic [7:0] OFS_EXTI    = 8'h30;
   localparam logic [7:0] OFS_PHAS    = 8'h34;
   localparam logic [7:0] OFS_RELAY   = 8'h38;
   localparam logic [7:0] OFS_OVH     = 8'h3C;
   localparam logic [7:0] OFS_SPEED   = 8'h40;
   localparam logic [7:0] OFS_LEADS   = 8'h44;
   // ---------------------------------------------------------------
   // control register fields
   // ---------------------------------------------------------------
   localparam int BIT_TRAP  = 0;
   localparam int BIT_ACTIVE_TIMER_ENABLE  = 3;
   localparam int BIT_INACTIVE_TIMER_ENABLE  = 4;
   localparam int BIT_OSC   = 7;
   // ---------------------------------------------------------------
   // line states
   // ---------------------------------------------------------------
   localparam logic [2:0] LS_OPEN    = 3'h0;
   localparam logic [2:0] LS_ONHOOK  = 3'h2;
   localparam logic [2:0] LS_RINGING = 3'h4;
   // ---------------------------------------------------------------
   // timing
   // ---------------------------------------------------------------
   localparam int CLK_MHZ    = 250;
   localparam int TICK_NS    = 125000;
   localparam int TICK_CYC   = TICK_NS * CLK_MHZ / 1000;
   localparam int MS_TICKS   = 8;
   localparam logic [15:0] RST_ZERO16 = 16'h0000;
   typedef struct packed {
      logic signed [15:0] tipLead;
      logic signed [15:0] ringLead;
   } rg_leads_s;
endpackage : rg_pkg

// >>> hw/rg_ringing_gen.sv
// Functional notes
// - drive waveform on both leads in antiphase, differential doubles
// - apply and remove ringing only at on-hook voltage crossings; the code applies it at once and removes it at a crossing or at zero wave
// - sine from two-pole resonator, programmable coefficient and amplitude
// - resonator makes one sample per millisecond
// - add programmed dc offset to either waveshape
// - active and inactive 16-bit cadence timers, 125 us units
// - cadence timers govern entry and exit of the ringing state
// - writing ringing code into line state field starts ringing
// - active timer expiry stops ringing, line goes on-hook transmission
// - inactive timer expiry restarts ringing while enabled and selected
// - trapezoid ramps by frequency step per sample up to amplitude
// - trapezoid initial phase is period count in 8 kHz samples
// - trapezoid amplitude scaled against 160.8 V full scale
// - cadence timers behave the same for trapezoid
//
// Implementation choices: the Wishbone register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module rg_ringing_gen
   import rg_pkg::*;
#(
   parameter int TICK_CYCLES = TICK_CYC
) (
   // clock and reset
   input  wire logic        mclk,
   input  wire logic        resetn,
   // wishbone slave
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [31:0] wb_dat_i,
   input  wire logic [3:0]  wb_sel_i,
   output var  logic [31:0] wb_dat_o,
   output var  logic        wb_ack_o,
   // external ringer sense samples
   input  wire logic [15:0] extVoltageSense,
   input  wire logic [15:0] extCurrentSense,
   // line drive
   output var  rg_leads_s   leads,
   output var  logic        ringingOn,
   output var  logic        relayDriverEnable
);
   // ---------------------------------------------------------------
   // elaboration check
   // ---------------------------------------------------------------
   if (TICK_CYCLES < 2) begin : g_chk
      $error("TICK_CYCLES must be at least 2");
   end

   typedef enum logic [1:0] {ST_IDLE, ST_ON, ST_OFF} rg_cad_e;

   // ---------------------------------------------------------------
   // registers
   // ---------------------------------------------------------------
   logic [4:0]  ctrl_q;
   logic [15:0] activePeriod_q;
   logic [15:0] inactivePeriod_q;
   logic [2:0]  lineState_q;
   logic [15:0] onhookVoltage_q;
   logic [15:0] dcOffset_q;
   logic [15:0] freqHigh_q;
   logic [15:0] freqLow_q;
   logic [15:0] amplitude_q;
   logic [15:0] initialPhase_q;
   logic [15:0] overhead_q;
   logic [15:0] speedup_q;
   logic        relay_q;
   logic        ack_q;
   logic [31:0] rdat_q;
   rg_cad_e     cad_q;
   logic [15:0] cadCnt_q;
   logic [31:0] tickCnt_q;
   logic [2:0]  msCnt_q;
   logic        oscOn_q;
   logic signed [23:0] y1_q;
   logic signed [23:0] y2_q;
   logic signed [15:0] wave_q;
   logic        rampUp_q;
   logic [15:0] phaseCnt_q;
   logic signed [15:0] tip_q;
   logic signed [15:0] ring_q;
   // sense synchroniser stages and accepted values
   logic [15:0] extV_a;
   logic [15:0] extV_b;
   logic [15:0] extV_c;
   logic [15:0] extV_q;
   logic [15:0] extI_a;
   logic [15:0] extI_b;
   logic [15:0] extI_c;
   logic [15:0] extI_q;

   // ---------------------------------------------------------------
   // bus decode
   // ---------------------------------------------------------------
   function automatic logic [15:0] wr16(input logic [15:0] old, input logic [31:0] d, input logic [3:0] s);
      wr16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
   endfunction : wr16

   wire        busReq    = wb_cyc_i && wb_stb_i && !ack_q;
   wire        busWr     = busReq && wb_we_i;
   wire        wrCtrl    = busWr && wb_adr_i == OFS_CTRL && wb_sel_i[0];
   wire        wrLine    = busWr && wb_adr_i == OFS_LINE && wb_sel_i[0];
   wire        ringReq   = wrLine && wb_dat_i[2:0] == LS_RINGING;
   wire        trapMode  = ctrl_q[BIT_TRAP];
   wire        active_timer_enable      = ctrl_q[BIT_ACTIVE_TIMER_ENABLE];
   wire        inactive_timer_enable      = ctrl_q[BIT_INACTIVE_TIMER_ENABLE];
   wire [2:0]  lineNext  = wrLine ? wb_dat_i[2:0] : lineState_q;

   // read multiplexer
   logic [31:0] rdMux;
   always_comb begin
      rdMux = 32'h0000_0000;
      unique case (wb_adr_i)
         OFS_CTRL:  rdMux[7:0] = {oscOn_q, 2'b00, ctrl_q};
         OFS_TALO:  rdMux[7:0] = activePeriod_q[7:0];
         OFS_TAHI:  rdMux[7:0] = activePeriod_q[15:8];
         OFS_TILO:  rdMux[7:0] = inactivePeriod_q[7:0];
         OFS_TIHI:  rdMux[7:0] = inactivePeriod_q[15:8];
         OFS_LINE:  rdMux[7:0] = {2'b00, lineState_q, lineState_q};
         OFS_VOH:   rdMux[15:0] = onhookVoltage_q;
         OFS_DCOFS: rdMux[15:0] = dcOffset_q;
         OFS_FRHI:  rdMux[15:0] = freqHigh_q;
         OFS_FRLO:  rdMux[15:0] = freqLow_q;
         OFS_AMP:   rdMux[15:0] = amplitude_q;
         OFS_EXTV:  rdMux[15:0] = extV_q;
         OFS_EXTI:  rdMux[15:0] = extI_q;
         OFS_PHAS:  rdMux[15:0] = initialPhase_q;
         OFS_RELAY: rdMux[7:0] = {7'h00, relay_q};
         OFS_OVH:   rdMux[15:0] = overhead_q;
         OFS_SPEED: rdMux[15:0] = speedup_q;
         OFS_LEADS: rdMux = {tip_q, ring_q};
         default:   rdMux = 32'h0000_0000;
      endcase
   end

   // ack and read data, one cycle after request
   always_ff @(posedge mclk) begin
      if (!resetn) begin
         ack_q  <= 1'b0;
         rdat_q <= 32'h0000_0000;
      end else begin
         ack_q  <= busReq;
         rdat_q <= busReq ? rdMux : 32'h0000_0000;
      end
   end

   // ---------------------------------------------------------------
   // software registers
   // ---------------------------------------------------------------
   always_ff @(posedge mclk) begin
      if (!resetn) begin
         ctrl_q           <= 5'h00;
         activePeriod_q   <= RST_ZERO16;
         inactivePeriod_q <= RST_ZERO16;
         onhookVoltage_q  <= RST_ZERO16;
         dcOffset_q       <= RST_ZERO16;
         freqHigh_q       <= RST_ZERO16;
         freqLow_q        <= RST_ZERO16;
         amplitude_q      <= RST_ZERO16;
         initialPhase_q   <= RST_ZERO16;
         overhead_q       <= RST_ZERO16;
         speedup_q        <= RST_ZERO16;
         relay_q          <= 1'b0;
      end else if (busWr) begin
         unique case (wb_adr_i)
            OFS_CTRL:  if (wb_sel_i[0]) ctrl_q <= {wb_dat_i[BIT_INACTIVE_TIMER_ENABLE], wb_dat_i[BIT_ACTIVE_TIMER_ENABLE], 2'b00, wb_dat_i[BIT_TRAP]};
            OFS_TALO:  if (wb_sel_i[0]) activePeriod_q[7:0] <= wb_dat_i[7:0];
            OFS_TAHI:  if (wb_sel_i[0]) activePeriod_q[15:8] <= wb_dat_i[7:0];
            OFS_TILO:  if (wb_sel_i[0]) inactivePeriod_q[7:0] <= wb_dat_i[7:0];
            OFS_TIHI:  if (wb_sel_i[0]) inactivePeriod_q[15:8] <= wb_dat_i[7:0];
            OFS_VOH:   onhookVoltage_q <= wr16(onhookVoltage_q, wb_dat_i, wb_sel_i);
            OFS_DCOFS: dcOffset_q <= wr16(dcOffset_q, wb_dat_i, wb_sel_i);
            OFS_FRHI:  freqHigh_q <= wr16(freqHigh_q, wb_dat_i, wb_sel_i);
            OFS_FRLO:  freqLow_q <= wr16(freqLow_q, wb_dat_i, wb_sel_i);
            OFS_AMP:   amplitude_q <= wr16(amplitude_q, wb_dat_i, wb_sel_i);
            OFS_PHAS:  initialPhase_q <= wr16(initialPhase_q, wb_dat_i, wb_sel_i);
            OFS_RELAY: if (wb_sel_i[0]) relay_q <= wb_dat_i[0];
            OFS_OVH:   overhead_q <= wr16(overhead_q, wb_dat_i, wb_sel_i);
            OFS_SPEED: speedup_q <= wr16(speedup_q, wb_dat_i, wb_sel_i);
            default:   ;
         endcase
      end
   end

   // external sense inputs, three stages, accept when last two agree
   always_ff @(posedge mclk) begin
      if (!resetn) begin
         extV_a <= RST_ZERO16;
         extV_b <= RST_ZERO16;
         extV_c <= RST_ZERO16;
         extV_q <= RST_ZERO16;
         extI_a <= RST_ZERO16;
         extI_b <= RST_ZERO16;
         extI_c <= RST_ZERO16;
         extI_q <= RST_ZERO16;
      end else begin
         extV_a <= extVoltageSense;
         extV_b <= extV_a;
         extV_c <= extV_b;
         extI_a <= extCurrentSense;
         extI_b <= extI_a;
         extI_c <= extI_b;
         if (extV_b == extV_c) extV_q <= extV_c;
         if (extI_b == extI_c) extI_q <= extI_c;
      end
   end

   // ---------------------------------------------------------------
   // 125 us tick and 1 ms sample strobe
   // ---------------------------------------------------------------
   wire tick   = tickCnt_q == 32'(TICK_CYCLES - 1);
   wire msTick = tick && msCnt_q == 3'(MS_TICKS - 1);
   always_ff @(posedge mclk) begin
      if (!resetn) begin
         tickCnt_q <= 32'h0000_0000;
         msCnt_q   <= 3'h0;
      end else begin
         tickCnt_q <= tick ? 32'h0000_0000 : tickCnt_q + 32'h0000_0001;
         if (tick) msCnt_q <= msCnt_q + 3'h1;
      end
   end

   // ---------------------------------------------------------------
   // cadence state machine
   // ---------------------------------------------------------------
   wire cadDone = cadCnt_q == RST_ZERO16;
   always_ff @(posedge mclk) begin
      if (!resetn) begin
         cad_q       <= ST_IDLE;
         cadCnt_q    <= RST_ZERO16;
         lineState_q <= LS_OPEN;
      end else begin
         lineState_q <= lineNext;
         if (ringReq) begin
            cad_q    <= ST_ON;
            cadCnt_q <= activePeriod_q;
         end else if (lineNext != LS_RINGING && cad_q == ST_ON) begin
            cad_q <= ST_IDLE;
         end else if (tick) begin
            unique case (cad_q)
               ST_IDLE: ;
               ST_ON: if (active_timer_enable) begin
                  if (cadDone) begin
                     cad_q       <= ST_OFF;
                     cadCnt_q    <= inactivePeriod_q;
                     lineState_q <= LS_ONHOOK;
                  end else cadCnt_q <= cadCnt_q - 16'h0001;
               end
               ST_OFF: if (inactive_timer_enable) begin
                  if (cadDone) begin
                     cad_q       <= ST_ON;
                     cadCnt_q    <= activePeriod_q;
                     lineState_q <= LS_RINGING;
                  end else cadCnt_q <= cadCnt_q - 16'h0001;
               end
               default: cad_q <= ST_IDLE;
            endcase
         end
      end
   end

   // ---------------------------------------------------------------
   // waveform: resonator or trapezoid ramp
   // ---------------------------------------------------------------
   wire signed [23:0] coeff  = {freqHigh_q[14:3], freqLow_q[14:3]};
   wire signed [47:0] prod   = coeff * y1_q;
   wire signed [23:0] yNext  = 24'(prod >>> 22) - y2_q;
   // trapezoid step is an 8-bit two's complement value, sign extended
   wire signed [15:0] step   = {{8{freqHigh_q[7]}}, freqHigh_q[7:0]};
   wire signed [15:0] ampS   = amplitude_q;
   wire signed [16:0] upVal  = 17'(wave_q) + 17'(step);
   wire signed [16:0] dnVal  = 17'(wave_q) - 17'(step);
   wire signed [16:0] sumOfs = 17'(wave_q) + 17'($signed(dcOffset_q));
   wire signed [15:0] withOfs = sumOfs > 17'sh07FFF ? 16'sh7FFF : sumOfs < -17'sh08000 ? -16'sh8000 : sumOfs[15:0];
   wire signed [15:0] outVal = oscOn_q ? withOfs : 16'sh0000;
   wire        wantRing = cad_q == ST_ON;
   wire        onVoc    = (outVal >= $signed(onhookVoltage_q) && wave_q <= 16'sh0000)
                          || !oscOn_q || (wave_q == 16'sh0000);

   always_ff @(posedge mclk) begin
      if (!resetn) begin
         oscOn_q    <= 1'b0;
         y1_q       <= 24'sh000000;
         y2_q       <= 24'sh000000;
         wave_q     <= 16'sh0000;
         rampUp_q   <= 1'b1;
         phaseCnt_q <= RST_ZERO16;
      end else begin
         if (wantRing != oscOn_q && onVoc && (tick || !oscOn_q)) begin
            oscOn_q <= wantRing;
            if (wantRing) begin
               y1_q       <= 24'(ampS) <<< 8;
               y2_q       <= 24'sh000000;
               wave_q     <= 16'sh0000;
               rampUp_q   <= 1'b1;
               phaseCnt_q <= initialPhase_q;
            end
         end else if (oscOn_q && !trapMode && msTick) begin
            y1_q   <= yNext;
            y2_q   <= y1_q;
            wave_q <= y1_q[23:8];
         end else if (oscOn_q && trapMode && tick) begin
            if (rampUp_q) wave_q <= upVal > 17'(ampS) ? ampS : upVal[15:0];
            else wave_q <= dnVal < -17'(ampS) ? -ampS : dnVal[15:0];
            if (phaseCnt_q <= 16'h0004) begin
               phaseCnt_q <= initialPhase_q;
               rampUp_q   <= 1'b1;
            end else begin
               phaseCnt_q <= phaseCnt_q - 16'h0001;
               if (phaseCnt_q == (initialPhase_q >> 1)) rampUp_q <= 1'b0;
            end
         end
      end
   end

   // ---------------------------------------------------------------
   // balanced drive
   // ---------------------------------------------------------------
   // tip carries the wave, ring its negation
   always_ff @(posedge mclk) begin
      if (!resetn) begin
         tip_q  <= 16'sh0000;
         ring_q <= 16'sh0000;
      end else begin
         tip_q  <= outVal;
         ring_q <= -outVal;
      end
   end

   // ---------------------------------------------------------------
   // outputs, all straight from flip-flops
   // ---------------------------------------------------------------
   assign wb_ack_o          = ack_q;
   assign wb_dat_o          = rdat_q;
   assign leads             = '{tipLead: tip_q, ringLead: ring_q};
   assign ringingOn         = oscOn_q;
   assign relayDriverEnable = relay_q;
endmodule : rg_ringing_gen
`default_nettype wire

// >>> verif/rg_checker_properties.sv
`timescale 1ns/1ps
`default_nettype none
module rg_checker
   import rg_pkg::*;
#(
   parameter int TICK_CYCLES = TICK_CYC
) (
   // clock and reset
   input wire logic        mclk,
   input wire logic        resetn,
   // wishbone
   input wire logic        wb_cyc_i,
   input wire logic        wb_stb_i,
   input wire logic        wb_we_i,
   input wire logic [7:0]  wb_adr_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [3:0]  wb_sel_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic        wb_ack_o,
   // line side
   input wire rg_leads_s   leads,
   input wire logic        ringingOn,
   input wire logic        relayDriverEnable
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!resetn);
   // request taken on this edge
   wire logic take = wb_cyc_i && wb_stb_i && !wb_ack_o;
   sequence s_ring_write;
      take && wb_we_i && wb_sel_i[0] && wb_adr_i == OFS_LINE && wb_dat_i[2:0] == LS_RINGING;
   endsequence
   sequence s_relay_write;
      take && wb_we_i && wb_sel_i[0] && wb_adr_i == OFS_RELAY;
   endsequence
   a_leads_antiphase: assert property (leads.ringLead == -leads.tipLead)
      else $error("leads not in antiphase");
   a_ack_next: assert property (take |=> wb_ack_o)
      else $error("no ack after request");
   a_ack_cause: assert property (!take |=> !wb_ack_o)
      else $error("ack without request");
   a_ring_start: assert property (s_ring_write |-> ##[1:8] ringingOn)
      else $error("ringing did not start");
   a_relay_write: assert property (s_relay_write |=> ##1 relayDriverEnable == $past(wb_dat_i[0], 2))
      else $error("relay enable not written");
   a_reset_quiet: assert property ($rose(resetn) |-> !ringingOn && !wb_ack_o && leads == '0)
      else $error("outputs busy after reset");
   a_sample_paced: assert property (ringingOn && $past(ringingOn, 4) && $changed(leads.tipLead)
      |=> ($stable(leads.tipLead) || !ringingOn)[*2])
      else $error("lead sample changed too soon");
   a_status_read: assert property (take && !wb_we_i && wb_adr_i == OFS_CTRL
      |=> wb_dat_o[BIT_OSC] == $past(ringingOn))
      else $error("status bit differs from oscillator");
   a_unmapped_zero: assert property (take && !wb_we_i && wb_adr_i == 8'h80 |=> wb_dat_o == 32'h0)
      else $error("unmapped read not zero");
endmodule : rg_checker
bind rg_ringing_gen rg_checker #(.TICK_CYCLES(TICK_CYCLES)) rg_checker_inst (.mclk(mclk), .resetn(resetn),
   .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
   .wb_sel_i(wb_sel_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .leads(leads), .ringingOn(ringingOn),
   .relayDriverEnable(relayDriverEnable));
`default_nettype wire

// >>> verif/rg_line_model.sv
`timescale 1ns/1ps
`default_nettype none
module rg_line_model
   import rg_pkg::*;
(
   // clock
   input  wire logic        mclk,
   // lead drive
   input  wire rg_leads_s   leads,
   // sense samples back
   output var  logic [15:0] voltSense = 16'h0000,
   output var  logic [15:0] currSense = 16'h0000
);
   // differential across the pair and a resistive load current
   always_ff @(posedge mclk) begin
      voltSense <= 16'(leads.tipLead - leads.ringLead);
      currSense <= 16'((leads.tipLead - leads.ringLead) >>> 3);
   end
endmodule : rg_line_model
`default_nettype wire

// >>> verif/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
   import rg_pkg::*;
   localparam int TC = 4;
   logic               mclk, resetn, cyc, stb, we, ack, ringingOn, relayEn;
   logic [7:0]         adr;
   logic [31:0]        wdat, rdat, q;
   logic [15:0]        voltSense, currSense;
   logic signed [15:0] mx;
   rg_leads_s          leads;
   int                 errTotal, nChecks, cycles, n;
   logic [7:0]         rwAdr [12] = '{OFS_TALO, OFS_TAHI, OFS_TILO, OFS_TIHI, OFS_VOH, OFS_DCOFS,
                                      OFS_FRHI, OFS_FRLO, OFS_AMP, OFS_PHAS, OFS_OVH, OFS_SPEED};
   rg_ringing_gen #(.TICK_CYCLES(TC)) rg_ringing_gen_inst (.mclk(mclk), .resetn(resetn), .wb_cyc_i(cyc),
      .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(4'hF), .wb_dat_o(rdat),
      .wb_ack_o(ack), .extVoltageSense(voltSense), .extCurrentSense(currSense), .leads(leads),
      .ringingOn(ringingOn), .relayDriverEnable(relayEn));
   rg_line_model rg_line_model_inst (.mclk(mclk), .leads(leads), .voltSense(voltSense), .currSense(currSense));
   // ---------------------------------------------------------------
   // clock, watchdog, shared tasks
   // ---------------------------------------------------------------
   initial begin
      mclk = 1'b0;
      forever #2 mclk = ~mclk;
   end
   // cut a hang short
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 20000) begin
         errTotal++;
         closeOut();
      end
   end
   task automatic closeOut;
      $display("checks %0d errors %0d", nChecks, errTotal);
      if (errTotal == 0 && nChecks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : closeOut
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      nChecks++;
      if (seen !== exp) begin
         errTotal++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   // one classic cycle, held until ack, then a gap cycle
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      @(posedge mclk);
      while (ack !== 1'b1) @(posedge mclk);
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge mclk);
   endtask : bus
   // count cycles until ringing reaches a level
   task automatic waitRing(input logic v);
      n = 0;
      while (ringingOn !== v) begin
         @(posedge mclk);
         n++;
      end
   endtask : waitRing
   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   initial begin
      {resetn, cyc, stb, we, adr, wdat} = '0;
      repeat (2) @(posedge mclk);
      resetn <= 1'b1;
      @(posedge mclk);
      // register access
      foreach (rwAdr[i]) begin
         bus(1'b1, rwAdr[i], 32'hFFFF_A5C0 | i);
         bus(1'b0, rwAdr[i], 0);
         check("reg", q & (i < 4 ? 32'hFF : 32'hFFFF), (i < 4 ? 32'hC0 : 32'hA5C0) | i);
      end
      bus(1'b1, 8'h80, 32'h1234);
      bus(1'b0, 8'h80, 0);
      check("unmapped", q, 0);
      bus(1'b1, OFS_CTRL, 32'h98);
      bus(1'b0, OFS_CTRL, 0);
      check("ctrl", q & 32'h99, 32'h18);
      bus(1'b1, OFS_RELAY, 32'h1);
      check("relay", relayEn, 1'b1);
      bus(1'b1, OFS_RELAY, 32'h0);
      // dc offset on a silent sine, cadence held
      bus(1'b1, OFS_VOH, 32'h7FFF);
      bus(1'b1, OFS_AMP, 32'h0);
      bus(1'b1, OFS_PHAS, 32'h0);
      bus(1'b1, OFS_DCOFS, 32'h0123);
      bus(1'b1, OFS_CTRL, 32'h00);
      bus(1'b1, OFS_LINE, LS_RINGING);
      repeat (20 * TC) @(posedge mclk);
      check("ringOn", ringingOn, 1'b1);
      check("tip", leads.tipLead, 32'h0123);
      bus(1'b0, OFS_EXTV, 0);
      check("extV", q, 32'h0246);
      bus(1'b0, OFS_EXTI, 0);
      check("extI", q, 32'h0048);
      bus(1'b0, OFS_LEADS, 0);
      check("leads", q, 32'h0123_FEDD);
      bus(1'b0, OFS_CTRL, 0);
      check("osc", q[BIT_OSC], 1'b1);
      repeat (40 * TC) @(posedge mclk);
      check("held", ringingOn, 1'b1);
      bus(1'b1, OFS_LINE, LS_ONHOOK);
      repeat (10 * TC) @(posedge mclk);
      check("stopped", ringingOn, 1'b0);
      // cadence: active 5 ticks, inactive 3 ticks
      bus(1'b1, OFS_DCOFS, 32'h0);
      bus(1'b1, OFS_TALO, 32'h5);
      bus(1'b1, OFS_TAHI, 32'h0);
      bus(1'b1, OFS_TILO, 32'h3);
      bus(1'b1, OFS_TIHI, 32'h0);
      bus(1'b1, OFS_CTRL, 32'h18);
      bus(1'b1, OFS_LINE, LS_RINGING);
      waitRing(1'b1);
      waitRing(1'b0);
      check("onTime", n >= 5 * TC && n <= 7 * TC, 1'b1);
      bus(1'b0, OFS_LINE, 0);
      check("onhook", q[5:3], LS_ONHOOK);
      waitRing(1'b1);
      check("offTime", n >= TC && n <= 5 * TC, 1'b1);
      bus(1'b1, OFS_CTRL, 32'h08);
      waitRing(1'b0);
      repeat (20 * TC) @(posedge mclk);
      check("frozen", ringingOn, 1'b0);
      bus(1'b1, OFS_LINE, LS_OPEN);
      // trapezoid ramp to amplitude
      bus(1'b1, OFS_CTRL, 32'h01);
      bus(1'b1, OFS_AMP, 32'h0040);
      bus(1'b1, OFS_FRHI, 32'h0010);
      bus(1'b1, OFS_PHAS, 32'h0040);
      bus(1'b1, OFS_LINE, LS_RINGING);
      mx = 16'sh0000;
      repeat (100 * TC) begin
         @(posedge mclk);
         if (leads.tipLead > mx) mx = leads.tipLead;
      end
      check("trapPeak", mx, 32'h0040);
      // sine: first resonator sample is the loaded amplitude
      bus(1'b1, OFS_LINE, LS_OPEN);
      waitRing(1'b0);
      bus(1'b1, OFS_CTRL, 32'h00);
      bus(1'b1, OFS_AMP, 32'h0111);
      bus(1'b1, OFS_FRHI, 32'h3F78);
      bus(1'b1, OFS_FRLO, 32'h6CE8);
      bus(1'b1, OFS_PHAS, 32'h0);
      bus(1'b1, OFS_LINE, LS_RINGING);
      while (leads.tipLead == 16'sh0000) @(posedge mclk);
      check("sineFirst", leads.tipLead, 32'h0111);
      closeOut();
   end
endmodule : tb
`default_nettype wire
